// *** bbx_pkg.sv ***
package bbx_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CMD    = 8'h00;
    localparam logic [7:0] OFS_FLAGS  = 8'h04;
    localparam logic [7:0] OFS_OPND   = 8'h08;
    localparam logic [7:0] OFS_PC     = 8'h0C;
    localparam logic [7:0] OFS_DISP   = 8'h10;
    localparam logic [7:0] OFS_RESULT = 8'h14;
    localparam logic [7:0] OFS_NPC    = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;

    // command field positions
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_COND_LSB = 8;
    localparam int CMD_BIT_LSB  = 16;
    localparam int CMD_LEN_LSB  = 24;
    localparam int CMD_R0_BIT   = 31;

    // flag bit positions
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_S = 2;
    localparam int FLG_O = 3;

    // status bit positions
    localparam int ST_TAKEN = 0;
    localparam int ST_TRUE  = 1;
    localparam int ST_RANGE = 2;
    localparam int ST_PAGE  = 3;
    localparam int ST_SIZE  = 4;
    localparam int ST_COND  = 5;

    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [19:0] RST_PC   = 20'h0_0000;

    // jump limits and constants
    localparam logic signed [31:0] JS_MIN   = 32'sd2;
    localparam logic signed [31:0] JS_MAX   = 32'sd9;
    localparam logic signed [31:0] JB_MIN   = -32'sd127;
    localparam logic signed [31:0] JB_MAX   = 32'sd128;
    localparam logic signed [31:0] JSG_MIN  = -32'sd126;
    localparam logic signed [31:0] JSG_MAX  = 32'sd129;
    localparam logic [19:0]        VEC_BASE = 20'hF_0000;
    localparam logic [7:0]         PAGE_MIN = 8'h12;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [4:0] {
        OP_WIDEN_B, OP_WIDEN_W, OP_AND_C, OP_NAND_C, OP_OR_C, OP_NOR_C,
        OP_XOR_C, OP_XNOR_C, OP_CBIT_STORE, OP_BRANCH, OP_JMP_S, OP_JMP_B,
        OP_JMP_W, OP_JMP_A, OP_JUMP_INDIRECT_W, OP_JUMP_INDIRECT_A, OP_JMP_VEC
    } bbx_op_e;

    // 14 condition codes; 14 and 15 are illegal
    typedef enum logic [3:0] {
        CND_C, CND_GTU, CND_Z, CND_N, CND_LE, CND_O, CND_GE,
        CND_NC, CND_LEU, CND_NZ, CND_PZ, CND_GT, CND_NO, CND_LT
    } bbx_cond_e;

endpackage

// *** bbx_exec.sv ***
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
// Summary of operation
// - byte sign widen copies bit 7 into bits 15..8
// - word sign widen only on data_reg_zero, bit 15 fills bits 31..16
// - bit_and_carry / bit_or_carry combine operand bit with carry into carry
// - bit_xor_carry xors operand bit into carry, operand left unchanged
// - cond_bit_store writes 1 when condition true, 0 when false
// - fourteen condition codes, eight simple carry/zero/sign/overflow tests
// - branch_on_cond loads target when true and displacement in range, else next sequential address
// - carry, zero, sign and unsigned-compare branches reach -127 to +128
// - signed and overflow branches reach -126 to +129
// - short jump reaches +2 to +9; byte jump -127 to +128
// - word jump uses 16-bit displacement; absolute loads 20-bit target
// - indirect word jump adds sign-extended 16-bit source to start address
// - indirect absolute jump loads 20-bit source directly
// - vector page jump adds F0000H to the fetched table entry
module bbx_exec
    import bbx_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // write address channel
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // write data channel
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // write response channel
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // read address channel
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // read data channel
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // core-side results
    output logic [19:0]            pc_out,
    output logic [3:0]             flags_out,
    output logic                   exec_done
);
    if (ADDR_W < 5 || ADDR_W > 32)
    begin : g_addr_w_check
        $error("ADDR_W must lie between 5 and 32");
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[8*i +: 8] = new_v[8*i +: 8];
        end
        return r;
    endfunction

    function automatic logic cond_eval(input logic [3:0] cd, input logic [3:0] f);
        logic c;
        logic z;
        logic sv;
        logic r;
        c  = f[FLG_C];
        z  = f[FLG_Z];
        sv = f[FLG_S] ^ f[FLG_O];
        r  = 1'b0;
        case (cd)
            CND_C:   r = c;
            CND_NC:  r = !c;
            CND_Z:   r = z;
            CND_NZ:  r = !z;
            CND_N:   r = f[FLG_S];
            CND_PZ:  r = !f[FLG_S];
            CND_O:   r = f[FLG_O];
            CND_NO:  r = !f[FLG_O];
            CND_GTU: r = c && !z;
            CND_LEU: r = !c || z;
            CND_LT:  r = sv;
            CND_GE:  r = !sv;
            CND_LE:  r = sv || z;
            CND_GT:  r = !sv && !z;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic signed_cond(input logic [3:0] cd);
        return cd == CND_LE || cd == CND_GE || cd == CND_GT || cd == CND_LT
            || cd == CND_O || cd == CND_NO;
    endfunction

    function automatic logic in_range(input logic signed [31:0] v,
                                      input logic signed [31:0] lo,
                                      input logic signed [31:0] hi);
        return v >= lo && v <= hi;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus state
    logic              aw_hold_reg, aw_hold_next;
    logic              w_hold_reg, w_hold_next;
    logic [ADDR_W-1:0] waddr_reg, waddr_next;
    logic [31:0]       wdata_reg, wdata_next;
    logic [3:0]        wstrb_reg, wstrb_next;
    logic              bvalid_reg, bvalid_next;
    logic [1:0]        bresp_reg, bresp_next;
    logic              rvalid_reg, rvalid_next;
    logic [1:0]        rresp_reg, rresp_next;
    logic [31:0]       rdata_reg, rdata_next;
    // block state
    logic [31:0]       cmd_reg, cmd_next;
    logic [3:0]        flags_reg, flags_next;
    logic [31:0]       opnd_reg, opnd_next;
    logic [19:0]       pc_reg, pc_next;
    logic [31:0]       disp_reg, disp_next;
    logic [31:0]       result_reg, result_next;
    logic [19:0]       npc_reg, npc_next;
    logic [5:0]        status_reg, status_next;
    logic              exec_reg, exec_next;
    logic              done_reg, done_next;

    // decoded command
    logic [4:0]        op_f;
    logic [3:0]        cd_f;
    logic [4:0]        bit_f;
    logic [19:0]       seq_pc;
    logic              src_bit;
    logic              ctrue;
    logic [7:0]        ofs_w;
    logic [7:0]        ofs_r;

    assign op_f   = cmd_reg[CMD_OP_LSB +: 5];
    assign cd_f   = cmd_reg[CMD_COND_LSB +: 4];
    assign bit_f  = cmd_reg[CMD_BIT_LSB +: 5];
    assign seq_pc = pc_reg + {16'h0000, cmd_reg[CMD_LEN_LSB +: 4]};
    assign src_bit = opnd_reg[bit_f];
    assign ctrue  = cond_eval(cd_f, flags_reg);
    assign ofs_w  = 8'(waddr_reg) & 8'hFC;
    assign ofs_r  = 8'(s_axi_araddr) & 8'hFC;

    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    assign pc_out        = npc_reg;
    assign flags_out     = flags_reg;
    assign exec_done     = done_reg;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic signed [31:0] d;
        d            = $signed(disp_reg);
        aw_hold_next = aw_hold_reg;
        w_hold_next  = w_hold_reg;
        waddr_next   = waddr_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rresp_next   = rresp_reg;
        rdata_next   = rdata_reg;
        cmd_next     = cmd_reg;
        flags_next   = flags_reg;
        opnd_next    = opnd_reg;
        pc_next      = pc_reg;
        disp_next    = disp_reg;
        result_next  = result_reg;
        npc_next     = npc_reg;
        status_next  = status_reg;
        exec_next    = 1'b0;
        done_next    = exec_reg;

        // write channels are taken independently, committed once both held
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_hold_next = 1'b1;
            waddr_next   = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_hold_next = 1'b1;
            wdata_next  = s_axi_wdata;
            wstrb_next  = s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready)
            bvalid_next = 1'b0;
        if (aw_hold_reg && w_hold_reg)
        begin
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = RESP_OKAY;
            case (ofs_w)
                OFS_CMD:
                begin
                    cmd_next  = merge(cmd_reg, wdata_reg, wstrb_reg);
                    exec_next = 1'b1;
                end
                OFS_FLAGS: flags_next = 4'(merge({28'h000_0000, flags_reg},
                                                 wdata_reg, wstrb_reg));
                OFS_OPND:  opnd_next = merge(opnd_reg, wdata_reg, wstrb_reg);
                OFS_PC:    pc_next = 20'(merge({12'h000, pc_reg}, wdata_reg, wstrb_reg));
                OFS_DISP:  disp_next = merge(disp_reg, wdata_reg, wstrb_reg);
                OFS_RESULT, OFS_NPC, OFS_STATUS: bresp_next = RESP_OKAY;
                default:   bresp_next = RESP_SLVERR;
            endcase
        end

        // read answer one cycle after the address is taken
        if (rvalid_reg && s_axi_rready)
            rvalid_next = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            case (ofs_r)
                OFS_CMD:    rdata_next = cmd_reg;
                OFS_FLAGS:  rdata_next = {28'h000_0000, flags_reg};
                OFS_OPND:   rdata_next = opnd_reg;
                OFS_PC:     rdata_next = {12'h000, pc_reg};
                OFS_DISP:   rdata_next = disp_reg;
                OFS_RESULT: rdata_next = result_reg;
                OFS_NPC:    rdata_next = {12'h000, npc_reg};
                OFS_STATUS: rdata_next = {26'h000_0000, status_reg};
                default:
                begin
                    rdata_next = RST_WORD;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end

        // execute the command one cycle after it is written
        if (exec_reg)
        begin
            status_next = 6'h00;
            npc_next    = seq_pc;
            result_next = opnd_reg;
            case (op_f)
                OP_WIDEN_B: result_next = {16'h0000, {8{opnd_reg[7]}}, opnd_reg[7:0]};
                OP_WIDEN_W:
                begin
                    if (cmd_reg[CMD_R0_BIT])
                        result_next = {{16{opnd_reg[15]}}, opnd_reg[15:0]};
                    else
                        status_next[ST_SIZE] = 1'b1;
                end
                OP_AND_C:  flags_next[FLG_C] = src_bit & flags_reg[FLG_C];
                OP_OR_C:   flags_next[FLG_C] = src_bit | flags_reg[FLG_C];
                OP_XOR_C:  flags_next[FLG_C] = src_bit ^ flags_reg[FLG_C];
                OP_NAND_C: flags_next[FLG_C] = !src_bit & flags_reg[FLG_C];
                OP_NOR_C:  flags_next[FLG_C] = !src_bit | flags_reg[FLG_C];
                OP_XNOR_C: flags_next[FLG_C] = !src_bit ^ flags_reg[FLG_C];
                OP_CBIT_STORE:
                begin
                    result_next[bit_f]   = ctrue;
                    status_next[ST_TRUE] = ctrue;
                    status_next[ST_COND] = cd_f > CND_LT;
                end
                OP_BRANCH:
                begin
                    status_next[ST_TRUE] = ctrue;
                    status_next[ST_COND] = cd_f > CND_LT;
                    if (signed_cond(cd_f))
                        status_next[ST_RANGE] = !in_range(d, JSG_MIN, JSG_MAX);
                    else
                        status_next[ST_RANGE] = !in_range(d, JB_MIN, JB_MAX);
                    if (ctrue && status_next[ST_RANGE] == 1'b0)
                    begin
                        npc_next              = pc_reg + disp_reg[19:0];
                        status_next[ST_TAKEN] = 1'b1;
                    end
                end
                OP_JMP_S, OP_JMP_B:
                begin
                    if (op_f == OP_JMP_S)
                        status_next[ST_RANGE] = !in_range(d, JS_MIN, JS_MAX);
                    else
                        status_next[ST_RANGE] = !in_range(d, JB_MIN, JB_MAX);
                    if (status_next[ST_RANGE] == 1'b0)
                    begin
                        npc_next              = pc_reg + disp_reg[19:0];
                        status_next[ST_TAKEN] = 1'b1;
                    end
                end
                OP_JMP_W:
                begin
                    npc_next = pc_reg + {{4{disp_reg[15]}}, disp_reg[15:0]};
                    status_next[ST_TAKEN] = 1'b1;
                end
                OP_JMP_A:
                begin
                    npc_next              = disp_reg[19:0];
                    status_next[ST_TAKEN] = 1'b1;
                end
                OP_JUMP_INDIRECT_W:
                begin
                    npc_next = pc_reg + {{4{opnd_reg[15]}}, opnd_reg[15:0]};
                    status_next[ST_TAKEN] = 1'b1;
                end
                OP_JUMP_INDIRECT_A:
                begin
                    npc_next              = opnd_reg[19:0];
                    status_next[ST_TAKEN] = 1'b1;
                end
                OP_JMP_VEC:
                begin
                    if (disp_reg[7:0] < PAGE_MIN)
                        status_next[ST_PAGE] = 1'b1;
                    else
                    begin
                        npc_next              = VEC_BASE + {4'h0, opnd_reg[15:0]};
                        status_next[ST_TAKEN] = 1'b1;
                    end
                end
                default: status_next[ST_COND] = 1'b1;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            waddr_reg   <= '0;
            wdata_reg   <= RST_WORD;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= RESP_OKAY;
            rdata_reg   <= RST_WORD;
            cmd_reg     <= RST_WORD;
            flags_reg   <= 4'h0;
            opnd_reg    <= RST_WORD;
            pc_reg      <= RST_PC;
            disp_reg    <= RST_WORD;
            result_reg  <= RST_WORD;
            npc_reg     <= RST_PC;
            status_reg  <= 6'h00;
            exec_reg    <= 1'b0;
            done_reg    <= 1'b0;
        end
        else
        begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg  <= w_hold_next;
            waddr_reg   <= waddr_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rresp_reg   <= rresp_next;
            rdata_reg   <= rdata_next;
            cmd_reg     <= cmd_next;
            flags_reg   <= flags_next;
            opnd_reg    <= opnd_next;
            pc_reg      <= pc_next;
            disp_reg    <= disp_next;
            result_reg  <= result_next;
            npc_reg     <= npc_next;
            status_reg  <= status_next;
            exec_reg    <= exec_next;
            done_reg    <= done_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_widen_byte: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_reg && op_f == OP_WIDEN_B |=> result_reg[15:8] == {8{$past(opnd_reg[7])}})
        else $error("byte widen fill wrong");
    a_widen_word: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_reg && op_f == OP_WIDEN_W |=> cmd_reg[CMD_R0_BIT] != status_reg[ST_SIZE]
            && (status_reg[ST_SIZE] || result_reg[31:16] == {16{opnd_reg[15]}}))
        else $error("word widen wrong");
    a_and_carry: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_reg && op_f == OP_AND_C && !src_bit |=> !flags_reg[FLG_C])
        else $error("and carry wrong");
    a_xor_carry: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_reg && op_f == OP_XOR_C |=> flags_reg[FLG_C] == ($past(src_bit)
            ^ $past(flags_reg[FLG_C])) && $stable(opnd_reg))
        else $error("xor carry wrong");
    a_nor_carry: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_reg && op_f == OP_NOR_C && !src_bit |=> flags_reg[FLG_C])
        else $error("nor carry wrong");
    a_cbit_store: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_reg && op_f == OP_CBIT_STORE |=> result_reg[bit_f] == $past(ctrue))
        else $error("cond bit store wrong");
    a_cond_gtu: assert property (@(posedge aclk) disable iff (!aresetn)
        cd_f == CND_GTU |-> ctrue == (flags_reg[FLG_C] && !flags_reg[FLG_Z]))
        else $error("higher cond wrong");
    a_branch_npc: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_reg && op_f == OP_BRANCH && !ctrue |=> npc_reg == $past(seq_pc)
            && !status_reg[ST_TAKEN])
        else $error("untaken branch wrong");
    a_vec_page: assert property (@(posedge aclk) disable iff (!aresetn)
        exec_reg && op_f == OP_JMP_VEC && disp_reg[7:0] >= PAGE_MIN
            |=> npc_reg[19:16] == 4'hF && done_reg)
        else $error("vector page target wrong");
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
    import bbx_pkg::*;
    logic        aclk;
    logic        aresetn;
    logic [7:0]  awaddr;
    logic [7:0]  araddr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, done;
    logic [1:0]  bresp, rresp, rs, bs;
    int          pulses = 0;
    logic [19:0] pc_o;
    logic [3:0]  flg_o;
    logic [31:0] res, npc, st, fl;
    logic        x, s;
    logic [15:0] okv = 16'h5355;
    int          num_errors;
    int          checked;
    int          ds[16] = '{128, 129, -127, -128, 129, 130, -126, -127,
                            2, 9, 1, 10, 128, 129, -127, -128};

    bbx_exec u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'b000),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'b000), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pc_out(pc_o),
        .flags_out(flg_o), .exec_done(done));

    // count exec_done pulses, one expected per command
    always @(posedge aclk)
        if (done)
            pulses <= pulses + 1;

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic limit(input int n);
        if (n >= 40)
        begin
            num_errors++;
            tally_and_finish;
        end
    endtask

    // handshakes are judged at the falling edge, acted on after the rising one
    task automatic wt(input logic [7:0] a, input logic [31:0] d);
        int   n;
        logic ta, tw, tk;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        tk = 1'b0;
        while (!tk && n < 40)
        begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tk = bvalid;
            bs = bresp;
            @(posedge aclk);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        @(posedge aclk);
        limit(n);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int   n;
        logic ta, tk;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        tk = 1'b0;
        while (!tk && n < 40)
        begin
            @(negedge aclk);
            ta = arvalid && arready;
            tk = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta)
                arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        @(posedge aclk);
        limit(n);
    endtask

    // load operands, issue one command, collect every result register
    task automatic run(input logic [4:0] op, input logic [3:0] cd, input logic [4:0] bt,
                       input logic [31:0] f, input logic [31:0] pcv,
                       input logic [31:0] opd, input logic [31:0] dsp);
        int p;
        p = pulses;
        wt(OFS_FLAGS, f);
        wt(OFS_OPND, opd);
        wt(OFS_PC, pcv);
        wt(OFS_DISP, dsp);
        wt(OFS_CMD, {1'b1, 3'b000, 4'h2, 3'b000, bt, 4'h0, cd, 3'b000, op});
        rd(OFS_RESULT, res, rs);
        rd(OFS_NPC, npc, rs);
        rd(OFS_STATUS, st, rs);
        rd(OFS_FLAGS, fl, rs);
        chk("exec_done", pulses - p, 32'd1);
    endtask

    function automatic logic cnd(input logic [3:0] c, input logic [3:0] f);
        logic [15:0] v;
        v = {2'b00, f[2] ^ f[3], ~f[3], ~(f[2] ^ f[3]) & ~f[1], ~f[2], ~f[1], ~f[0] | f[1],
             ~f[0], ~(f[2] ^ f[3]), f[3], (f[2] ^ f[3]) | f[1], f[2], f[1], f[0] & ~f[1], f[0]};
        return v[c];
    endfunction

    ////////////////////////////////////////////////////////////////
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    initial
    begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
        {awaddr, araddr, wdata} = 48'h0;
        num_errors = 0;
        checked = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h20, res, rs);
        chk("unmapped_resp", rs, RESP_SLVERR);
        wt(8'h20, 32'h0000_0000);
        chk("unmapped_wr", bs, RESP_SLVERR);
        run(OP_WIDEN_B, 0, 0, 0, 0, 32'h0000_0080, 0);
        chk("widen_b_neg", res[15:0], 16'hFF80);
        chk("write_resp", bs, RESP_OKAY);
        run(OP_WIDEN_B, 0, 0, 0, 0, 32'h0000_FF7F, 0);
        chk("widen_b_pos", res[15:0], 16'h007F);
        run(OP_WIDEN_W, 0, 0, 0, 0, 32'h0000_8000, 0);
        chk("widen_w", res, 32'hFFFF_8000);
        wt(OFS_CMD, 32'h0000_0001);
        rd(OFS_STATUS, st, rs);
        chk("widen_w_size", st[ST_SIZE], 1'b1);
        for (int k = 2; k < 8; k++)
            for (int b = 0; b < 4; b++)
            begin
                run(5'(k), 0, 5, {3'b101, b[0]}, 0, b[1] ? 32'h0000_0020 : 32'hFFFF_FFDF, 0);
                s = b[1] ^ k[0];
                x = k < 4 ? s & b[0] : (k < 6 ? s | b[0] : s ^ b[0]);
                chk("carry", fl[3:0], {3'b101, x});
                chk("flags_port", flg_o, {3'b101, x});
            end
        for (int c = 0; c < 14; c++)
            for (int f = 0; f < 16; f++)
            begin
                x = cnd(4'(c), 4'(f));
                run(OP_BRANCH, 4'(c), 0, 32'(f), 32'h0000_1000, 0, 32'h0000_0010);
                chk("branch_npc", npc, x ? 32'h0000_1010 : 32'h0000_1002);
                run(OP_CBIT_STORE, 4'(c), 3, 32'(f), 0, x ? 32'h0 : 32'hFFFF_FFFF, 0);
                chk("bit_store", res[3], x);
            end
        for (int i = 0; i < 16; i++)
        begin
            run(i < 8 ? OP_BRANCH : (i < 12 ? OP_JMP_S : OP_JMP_B), i < 4 ? CND_C : CND_O,
                0, 32'h9, 32'h0000_1000, 0, ds[i]);
            chk("range_npc", npc, okv[i] ? 32'h1000 + ds[i] : 32'h0000_1002);
            chk("range_flag", st[ST_RANGE], !okv[i]);
        end
        run(OP_BRANCH, 4'hE, 0, 32'hF, 32'h0000_1000, 0, 32'h0000_0010);
        chk("bad_cond", st[ST_COND], 1'b1);
        chk("bad_cond_npc", npc, 32'h0000_1002);
        run(OP_JMP_A, 0, 0, 0, 32'h0000_1000, 0, 32'h000A_BCDE);
        chk("jmp_abs", npc, 32'h000A_BCDE);
        chk("pc_port", pc_o, 32'h000A_BCDE);
        run(OP_JMP_W, 0, 0, 0, 32'h0000_9000, 0, 32'hFFFF_F000);
        chk("jmp_word", npc, 32'h0000_8000);
        run(OP_JUMP_INDIRECT_W, 0, 0, 0, 32'h0001_0000, 32'h0000_8000, 0);
        chk("jump_indirect_word", npc, 32'h0000_8000);
        run(OP_JUMP_INDIRECT_A, 0, 0, 0, 32'h0000_1000, 32'h000F_1234, 0);
        chk("jump_indirect_abs", npc, 32'h000F_1234);
        run(OP_JMP_VEC, 0, 0, 0, 32'h0000_1000, 32'h0000_5678, 32'h12);
        chk("vec_low", npc, 32'h000F_5678);
        run(OP_JMP_VEC, 0, 0, 0, 32'h0000_1000, 32'h0000_ABCD, 32'hFF);
        chk("vec_high", npc, 32'h000F_ABCD);
        run(OP_JMP_VEC, 0, 0, 0, 32'h0000_1000, 32'h0000_5678, 32'h11);
        chk("vec_bad", st[ST_PAGE], 1'b1);
        tally_and_finish;
    end
endmodule
